// ===== src/fsp_defs.svh
// Constants for the flash status polling controller
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH

// Register map of the controller
`define FSP_REG_CTRL      4'h0
`define FSP_REG_ADDR      4'h1
`define FSP_REG_STATUS    4'h2
`define FSP_REG_DATA      4'h3
`define FSP_REG_TIMEOUT   4'h4

// Command codes in CTRL[1:0]
`define FSP_CMD_POLL      2'h1
`define FSP_CMD_RESET     2'h2
`define FSP_CMD_SECT_ADD  2'h3

// Status bit positions
`define FSP_ST_BUSY       0
`define FSP_ST_DONE       1
`define FSP_ST_FAIL       2
`define FSP_ST_ERASE_ON   3
`define FSP_ST_ADD_MISS   4
`define FSP_ST_RDY_PIN    5

// Flash data bit positions
`define FSP_BIT_POLL      7
`define FSP_BIT_TOG1      6
`define FSP_BIT_LIMIT     5
`define FSP_BIT_ETIMER    3
`define FSP_BIT_TOG2      2

// Reset value of the tries limit
`define FSP_TRIES_RST     16'hFFFF

// Bus cycle timing: 70 ns read and write cycle at 10 ns clock
`define FSP_CYCLE_NS      70
`define FSP_CLK_NS        10
`define FSP_CYCLE_CLKS    ((`FSP_CYCLE_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
// Reset command data and unlock-free sector erase confirm data
`define FSP_RESET_DATA    8'hF0
`define FSP_SECT_DATA     8'h30

`endif

// ===== src/fsp_pkg.sv
// Types for the flash status polling controller
package fsp_pkg;
    typedef enum logic [7:0] {
        FSP_IDLE  = 8'h01,
        FSP_RD1   = 8'h02,
        FSP_RD2   = 8'h04,
        FSP_RD3   = 8'h08,
        FSP_WR    = 8'h10,
        FSP_CHK0  = 8'h20,
        FSP_CHK1  = 8'h40,
        FSP_GAP   = 8'h80
    } fsp_state_t;

    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic [19:0] addr;
        logic [7:0]  dout;
        logic        doe;
    } fsp_pins_t;
endpackage : fsp_pkg

// ===== src/fsp_ctrl.sv
// Host controller that polls flash write status and issues reset and erase adds
`timescale 1ns/1ps
`include "fsp_defs.svh"
module fsp_ctrl
    import fsp_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // Flash pins
    output logic             flash_ce_n,
    output logic             flash_oe_n,
    output logic             flash_we_n,
    output logic [19:0]      flash_addr,
    output logic [7:0]       flash_dq_o,
    output logic             flash_dq_oe,
    input  wire logic [7:0]  flash_dq_i,
    input  wire logic        ready_busy_output
);
    fsp_state_t  state_q, state_d;
    fsp_pins_t   pins_q, pins_d;
    logic [3:0]  cnt_q, cnt_d;
    logic [7:0]  first_q, first_d;
    logic [7:0]  data_q, data_d;
    logic [19:0] addr_q, addr_d;
    logic [15:0] tries_q, tries_d, tlim_q, tlim_d, used_q, used_d;
    logic        busy_q, busy_d, done_q, done_d, fail_q, fail_d;
    logic        eon_q, eon_d, miss_q, miss_d, add_q, add_d, rdy_q;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0]  wdata_q, wdata_d;
    logic        toggling;

    // Toggle bit one changed between the two reads
    assign toggling = (first_q[`FSP_BIT_TOG1] != flash_dq_i[`FSP_BIT_TOG1]);

    // Next-state logic of the polling sequencer
    always_comb begin
        state_d = state_q;
        pins_d  = pins_q;
        cnt_d   = cnt_q;
        first_d = first_q;
        data_d  = data_q;
        addr_d  = addr_q;
        tries_d = tries_q;
        tlim_d  = tlim_q;
        used_d  = used_q;
        busy_d  = busy_q;
        done_d  = done_q;
        fail_d  = fail_q;
        eon_d   = eon_q;
        miss_d  = miss_q;
        add_d   = add_q;
        wdata_d = wdata_q;
        rdata_d = 32'h0000_0000;
        if (reg_wr && reg_addr == `FSP_REG_ADDR)
            addr_d = reg_wdata[19:0];
        if (reg_wr && reg_addr == `FSP_REG_TIMEOUT)
            tlim_d = reg_wdata[15:0];
        // Register read, answer one cycle later
        if (reg_rd) begin
            case (reg_addr)
                `FSP_REG_ADDR:    rdata_d = {12'h000, addr_q};
                `FSP_REG_DATA:    rdata_d = {24'h00_0000, data_q};
                `FSP_REG_TIMEOUT: rdata_d = {tlim_q, used_q};
                `FSP_REG_STATUS:  rdata_d = {26'h000_0000, rdy_q, miss_q, eon_q,
                                             fail_q, done_q, busy_q};
                default:          rdata_d = 32'h0000_0000;
            endcase
        end
        case (state_q)
            FSP_IDLE: begin
                pins_d = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                           addr: addr_q, dout: 8'h00, doe: 1'b0};
                if (reg_wr && reg_addr == `FSP_REG_CTRL) begin
                    case (reg_wdata[1:0])
                        `FSP_CMD_POLL: begin
                            // A new poll always begins with the double read
                            busy_d  = 1'b1;
                            done_d  = 1'b0;
                            fail_d  = 1'b0;
                            tries_d = 16'h0000;
                            add_d   = 1'b0;
                            state_d = FSP_RD1;
                        end
                        `FSP_CMD_RESET: begin
                            busy_d  = 1'b1;
                            wdata_d = `FSP_RESET_DATA;
                            add_d   = 1'b0;
                            state_d = FSP_WR;
                        end
                        `FSP_CMD_SECT_ADD: begin
                            // Timer flag checked before the added sector
                            busy_d  = 1'b1;
                            miss_d  = 1'b0;
                            state_d = FSP_CHK0;
                        end
                        default: state_d = FSP_IDLE;
                    endcase
                end
                cnt_d = 4'h0;
            end
            FSP_RD1, FSP_RD2, FSP_RD3, FSP_CHK0, FSP_CHK1: begin
                // One read cycle of the full byte at the valid address
                pins_d.ce_n = 1'b0;
                pins_d.oe_n = 1'b0;
                pins_d.doe  = 1'b0;
                pins_d.addr = addr_q;
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == 4'(`FSP_CYCLE_CLKS)) begin
                    cnt_d = 4'h0;
                    pins_d.ce_n = 1'b1;
                    pins_d.oe_n = 1'b1;
                    state_d = FSP_GAP;
                    data_d  = flash_dq_i;
                    case (state_q)
                        FSP_RD1: begin
                            first_d = flash_dq_i;
                            state_d = FSP_RD2;
                        end
                        FSP_RD2: begin
                            if (!toggling) begin
                                done_d = 1'b1;
                                busy_d = 1'b0;
                                state_d = FSP_IDLE;
                            end else if (flash_dq_i[`FSP_BIT_LIMIT]) begin
                                first_d = flash_dq_i;
                                state_d = FSP_RD3;
                            end else if (tries_q == tlim_q) begin
                                // Give up for now; next poll starts over
                                busy_d = 1'b0;
                                state_d = FSP_IDLE;
                            end else begin
                                tries_d = tries_q + 16'h0001;
                                first_d = flash_dq_i;
                            end
                        end
                        FSP_RD3: begin
                            done_d = 1'b1;
                            fail_d = toggling;
                            busy_d = 1'b0;
                            state_d = FSP_IDLE;
                        end
                        FSP_CHK0: begin
                            if (flash_dq_i[`FSP_BIT_ETIMER]) begin
                                // Erase already running, add refused
                                eon_d = 1'b1;
                                miss_d = 1'b1;
                                busy_d = 1'b0;
                                state_d = FSP_IDLE;
                            end else begin
                                wdata_d = `FSP_SECT_DATA;
                                add_d   = 1'b1;
                                state_d = FSP_WR;
                            end
                        end
                        default: begin
                            // Second check after the add
                            eon_d  = flash_dq_i[`FSP_BIT_ETIMER];
                            miss_d = flash_dq_i[`FSP_BIT_ETIMER];
                            busy_d = 1'b0;
                            state_d = FSP_IDLE;
                        end
                    endcase
                end
            end
            FSP_WR: begin
                // One write cycle with data driven
                pins_d.ce_n = 1'b0;
                pins_d.we_n = 1'b0;
                pins_d.doe  = 1'b1;
                pins_d.dout = wdata_q;
                pins_d.addr = addr_q;
                cnt_d = cnt_q + 4'h1;
                if (cnt_q == 4'(`FSP_CYCLE_CLKS)) begin
                    cnt_d = 4'h0;
                    pins_d.ce_n = 1'b1;
                    pins_d.we_n = 1'b1;
                    if (add_q) begin
                        state_d = FSP_CHK1;
                    end else begin
                        busy_d = 1'b0;
                        fail_d = 1'b0;
                        eon_d  = 1'b0;
                        state_d = FSP_IDLE;
                    end
                end
            end
            FSP_GAP: begin
                // Bus idle one more cycle, two in all, before the next read
                pins_d.doe = 1'b0;
                state_d = busy_q ? FSP_RD2 : FSP_IDLE;
            end
            default: state_d = FSP_IDLE;
        endcase
        used_d = tries_d;
    end

    // State registers
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= FSP_IDLE;
            pins_q  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                         addr: 20'h0_0000, dout: 8'h00, doe: 1'b0};
            cnt_q   <= 4'h0;
            first_q <= 8'h00;
            data_q  <= 8'h00;
            addr_q  <= 20'h0_0000;
            tries_q <= 16'h0000;
            tlim_q  <= `FSP_TRIES_RST;
            used_q  <= 16'h0000;
            busy_q  <= 1'b0;
            done_q  <= 1'b0;
            fail_q  <= 1'b0;
            eon_q   <= 1'b0;
            miss_q  <= 1'b0;
            add_q   <= 1'b0;
            wdata_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
            rdy_q   <= 1'b1;
        end else begin
            state_q <= state_d;
            pins_q  <= pins_d;
            cnt_q   <= cnt_d;
            first_q <= first_d;
            data_q  <= data_d;
            addr_q  <= addr_d;
            tries_q <= tries_d;
            tlim_q  <= tlim_d;
            used_q  <= used_d;
            busy_q  <= busy_d;
            done_q  <= done_d;
            fail_q  <= fail_d;
            eon_q   <= eon_d;
            miss_q  <= miss_d;
            add_q   <= add_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            rdy_q   <= ready_busy_output;
        end
    end

    // Outputs straight from flip-flops
    assign reg_rdata   = rdata_q;
    assign flash_ce_n  = pins_q.ce_n;
    assign flash_oe_n  = pins_q.oe_n;
    assign flash_we_n  = pins_q.we_n;
    assign flash_addr  = pins_q.addr;
    assign flash_dq_o  = pins_q.dout;
    assign flash_dq_oe = pins_q.doe;
endmodule : fsp_ctrl

// ===== bench/fsp_ctrl_checker.sv
// Checker for the flash status polling controller
`timescale 1ns/1ps
`include "fsp_defs.svh"
module fsp_ctrl_checker (
    // Clock, reset and register port
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [3:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // Flash pins
    input wire logic        flash_ce_n,
    input wire logic        flash_oe_n,
    input wire logic        flash_we_n,
    input wire logic [19:0] flash_addr,
    input wire logic [7:0]  flash_dq_o,
    input wire logic        flash_dq_oe,
    input wire logic [7:0]  flash_dq_i,
    input wire logic        ready_busy_output
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [3:0]  rds_q, rds_d;
    logic        lim_q, lim_d, st_q, st_d, oe_q, oe_d;
    logic [19:0] adr_q, adr_d;
    // Reads started and limit flag seen since the last poll order
    always_comb begin
        rds_d = rds_q + {3'h0, (!flash_oe_n && oe_q && rds_q != 4'hF)};
        lim_d = lim_q || (!flash_oe_n && flash_dq_i[`FSP_BIT_LIMIT]);
        st_d  = reg_rd && reg_addr == `FSP_REG_STATUS;
        oe_d  = flash_oe_n;
        adr_d = (reg_wr && reg_addr == `FSP_REG_ADDR) ? reg_wdata[19:0] : adr_q;
        if (reg_wr && reg_addr == `FSP_REG_CTRL && reg_wdata[1:0] == `FSP_CMD_POLL) begin
            rds_d = 4'h0;
            lim_d = 1'b0;
        end
    end
    // Helper registers
    always_ff @(posedge clk) begin
        if (rst) begin
            rds_q <= 4'h0;
            lim_q <= 1'b0;
            st_q  <= 1'b0;
            oe_q  <= 1'b1;
            adr_q <= 20'h0_0000;
        end else begin
            rds_q <= rds_d;
            lim_q <= lim_d;
            st_q  <= st_d;
            oe_q  <= oe_d;
            adr_q <= adr_d;
        end
    end
    chk_two_reads: assert property (st_q && reg_rdata[`FSP_ST_DONE] |-> rds_q >= 4'h2)
        else $error("done reported before two full reads");
    chk_read_len: assert property ($fell(flash_oe_n) |-> !flash_oe_n[*7] ##1 flash_oe_n)
        else $error("read strobe not seven cycles long");
    chk_fail_limit: assert property (st_q && reg_rdata[`FSP_ST_FAIL] |-> lim_q)
        else $error("failure reported without limit flag seen");
    chk_write_data: assert property (!flash_we_n |-> flash_dq_oe && !flash_ce_n)
        else $error("write strobe without data drive or chip select");
    chk_write_code: assert property (!flash_we_n |-> flash_dq_o inside {8'hF0, 8'h30})
        else $error("unexpected command byte on write");
    chk_we_pulse: assert property ($fell(flash_we_n) |-> ##[1:12] flash_we_n)
        else $error("write strobe stuck low");
    chk_read_addr: assert property (!flash_oe_n |-> flash_addr == adr_q)
        else $error("status read at other than the set address");
    chk_no_clash: assert property (!flash_oe_n |-> !flash_dq_oe && flash_we_n)
        else $error("data driven during a read");
    cover property (st_q && reg_rdata[`FSP_ST_DONE]);
    cover property (st_q && reg_rdata[`FSP_ST_FAIL]);
    cover property (st_q && reg_rdata[`FSP_ST_ADD_MISS]);
endmodule : fsp_ctrl_checker

bind fsp_ctrl fsp_ctrl_checker fsp_ctrl_checker_i (.clk(clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_addr(flash_addr), .flash_dq_o(flash_dq_o), .flash_dq_oe(flash_dq_oe),
    .flash_dq_i(flash_dq_i), .ready_busy_output(ready_busy_output));

// ===== bench/fsp_flash_model.sv
// Behavioural flash device answering status reads and command writes
`timescale 1ns/1ps
`include "fsp_defs.svh"
module fsp_flash_model (
    // Flash pins from the controller
    input wire logic       ce_n,
    input wire logic       oe_n,
    input wire logic       we_n,
    input wire logic [7:0] dq_in,
    // Data and ready back
    output logic [7:0]     dq_out,
    output logic           ready_busy_output
);
    int         busy_left = 0;  // Reads until the operation ends
    int         window    = 0;  // Reads left in the sector selection window
    int         adds      = 0;
    int         resets    = 0;
    bit         erase     = 0;
    bit         fail      = 0;
    bit         chip      = 0;  // Chip erase: no selection window
    logic [7:0] pdata     = 8'h00;
    logic       tog       = 1'b0;
    logic [7:0] stat;
    logic [7:0] last      = 8'h00;
    wire        active    = busy_left > 0 || fail;
    // Status byte while busy, array data once done
    always_comb begin
        stat = pdata;
        if (active) begin
            stat = {erase ? 1'b0 : ~pdata[7], tog, fail, 1'b0,
                    erase && (window == 0 || chip), erase && tog, 2'h0};
        end
    end
    // Released bus shows no stale value
    assign dq_out = (!ce_n && !oe_n) ? stat : ~last;
    assign ready_busy_output = !active;
    // Each finished read toggles while active and counts down; busy count holds on fail
    always @(posedge oe_n) begin
        last = stat;
        if (active) tog = !tog;
        if (busy_left > 0 && !fail) busy_left--;
        if (window > 0) window--;
    end
    // Command writes: reset, sector addition inside the window, all others ignored
    always @(negedge we_n) begin
        #1;
        if (dq_in == `FSP_RESET_DATA) begin
            busy_left = 0;
            fail = 0;
            resets++;
        end else if (dq_in == `FSP_SECT_DATA && erase && !chip && window > 0) begin
            window = 8;
            adds++;
        end
    end
endmodule : fsp_flash_model

// ===== bench/testbench.sv
// Self-checking testbench for the flash status polling controller
`timescale 1ns/1ps
`include "fsp_defs.svh"
module testbench;
    logic        clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rd;
    logic        ce_n, oe_n, we_n, dq_oe, rdy;
    logic [19:0] faddr;
    logic [7:0]  dq_o, dq_i;
    int          miscompares = 0, samples_checked = 0, k, n;
    always #5 clk = ~clk;
    fsp_ctrl fsp_ctrl_i (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_ce_n(ce_n),
        .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(faddr), .flash_dq_o(dq_o),
        .flash_dq_oe(dq_oe), .flash_dq_i(dq_i), .ready_busy_output(rdy));
    fsp_flash_model fsp_flash_model_i (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dq_in(dq_o),
        .dq_out(dq_i), .ready_busy_output(rdy));
    // Compare and count
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    // Register port cycles
    task automatic reg_write(logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(logic [3:0] a);
        @(posedge clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask : reg_read
    // Issue an order and wait, bounded, until busy drops
    task automatic run(logic [1:0] cmd);
        reg_write(`FSP_REG_CTRL, {30'h0, cmd});
        repeat (2) @(posedge clk);
        for (n = 0; n < 800; n++) begin
            reg_read(`FSP_REG_STATUS);
            if (rd[`FSP_ST_BUSY] === 1'b0) break;
        end
        if (n == 800) begin
            check("timeout", 0, 1);
            tally_and_finish();
        end
    endtask : run
    // Ready, fail and busy bits expected at the end of a poll
    function automatic logic [2:0] exp_end(bit f);
        return f ? 3'b010 : 3'b100;
    endfunction : exp_end
    // Ready, fail and busy bits picked out of a status word
    function automatic logic [2:0] seen_end(logic [31:0] r);
        return {r[`FSP_ST_RDY_PIN], r[`FSP_ST_FAIL], r[`FSP_ST_BUSY]};
    endfunction : seen_end
    task automatic poll_ok(int reads, logic [7:0] d);
        fsp_flash_model_i.busy_left = reads;
        fsp_flash_model_i.pdata = d;
        run(`FSP_CMD_POLL);
        check("end", exp_end(0), seen_end(rd));
        check("done", 1, rd[`FSP_ST_DONE]);
        reg_read(`FSP_REG_DATA);
        check("data", d, rd[7:0]);
    endtask : poll_ok
    initial begin
        k = $urandom(4894);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        reg_read(`FSP_REG_STATUS);
        check("status rst", 3'h0, rd[2:0]);
        reg_read(`FSP_REG_TIMEOUT);
        check("limit rst", 16'hFFFF, rd[31:16]);
        reg_read(4'hF);
        check("unmapped", 0, rd);
        // Random program polls, first already finished
        for (k = 0; k < 6; k++) begin
            reg_write(`FSP_REG_ADDR, {12'h0, 20'($urandom)});
            poll_ok(k == 0 ? 0 : $urandom_range(1, 6), 8'($urandom));
        end
        // Timing limit failure, then reset order
        fsp_flash_model_i.busy_left = 3;
        fsp_flash_model_i.fail = 1;
        run(`FSP_CMD_POLL);
        check("fail end", exp_end(1), seen_end(rd));
        run(`FSP_CMD_RESET);
        check("reset seen", 1, fsp_flash_model_i.resets);
        poll_ok(2, 8'hA5);
        // Sector additions inside and after the selection window
        fsp_flash_model_i.erase = 1;
        fsp_flash_model_i.window = 8;
        fsp_flash_model_i.busy_left = 25;
        run(`FSP_CMD_SECT_ADD);
        check("add ok", 0, rd[`FSP_ST_ADD_MISS]);
        check("adds", 1, fsp_flash_model_i.adds);
        fsp_flash_model_i.window = 0;
        run(`FSP_CMD_SECT_ADD);
        check("add late", 1, rd[`FSP_ST_ADD_MISS]);
        check("adds late", 1, fsp_flash_model_i.adds);
        // Chip erase has no window, so an add is refused
        fsp_flash_model_i.chip = 1;
        fsp_flash_model_i.window = 8;
        run(`FSP_CMD_SECT_ADD);
        check("add chip", 1, rd[`FSP_ST_ADD_MISS]);
        check("adds chip", 1, fsp_flash_model_i.adds);
        poll_ok(fsp_flash_model_i.busy_left, 8'hFF);
        tally_and_finish();
    end
endmodule : testbench
